// ==== dv/interrupt_source_priority_logic_bench.sv ====
// Self-checking bench for the interrupt source and priority logic.
`timescale 1ns/1ps
`default_nettype none
module interrupt_source_priority_logic_bench;
  import isp_pkg::*;
  typedef struct packed {logic [7:0] bit_n; logic [7:0] vec;} isp_row_t;
  isp_row_t rows [5] = '{16'h0018, 16'h021b, 16'h0420, 16'h1e50, 16'h306e};
  logic clk = 0, rst = 1, nmi = 1, nes = 0, use_lv = 0, auto_ack = 0;
  logic hd, wake, np, creq, dreq;
  logic [N_EXT-1:0] pins = '1, en = '0, clr = '0, flags;
  logic [2*N_EXT-1:0] sense = '0;
  logic [N_GRP*LVL_W-1:0] lvl = '0;
  logic [N_PER-1:0] pf = '0, pe = '0, pd = '0;
  logic [VEC_W-1:0] hv, vn, dv;
  logic [ADDR_W-1:0] va;
  logic [LVL_W-1:0] rl;
  int fail_count = 0, total_checks = 0;
  isp_top u_dut (.clk_i(clk), .rst_i(rst), .nmi_pin_i(nmi), .nonmaskable_edge_select_i(nes),
    .external_request_lines_i(pins), .sense_control_setting_i(sense), .request_enable_bits_i(en),
    .status_clear_i(clr), .priority_level_fields_i(lvl), .use_levels_i(use_lv), .periph_flag_i(pf),
    .periph_enable_i(pe), .periph_to_dtc_i(pd), .handled_i(hd), .handled_vector_i(hv),
    .request_status_flags_o(flags), .wake_o(wake), .nmi_pending_o(np), .cpu_request_o(creq),
    .vector_number_o(vn), .vector_address_o(va), .request_level_o(rl), .dtc_request_o(dreq), .dtc_vector_o(dv));
  isp_cpu_model u_cpu (.clk_i(clk), .rst_i(rst), .auto_i(auto_ack), .req_i(creq), .vec_i(vn),
    .ack_o(hd), .ack_vec_o(hv));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic final_report;
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : final_report
  initial forever #2 clk = ~clk;
  // Bounded run: the whole sequence needs well under a thousand cycles.
  initial
  begin
    #8000;
    fail_count++;
    final_report();
  end
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial
  begin
    cyc(8);
    rst = 0;
    cyc(1);
    chk({creq, np, wake, dreq, flags}, 16'h0);
    $display("reset test done");
    foreach (rows[i])
    begin
      pf = N_PER'(1) << rows[i].bit_n;
      pe[rows[i].bit_n] = 1;
      cyc(2);
      chk(creq, 1);
      chk(vn, rows[i].vec);
      chk(va, {6'h0, rows[i].vec, 2'h0});
      pe = '0;
      cyc(1);
      chk(creq, 0);
    end
    pf = '0;
    $display("peripheral table done");
    // Line n uses sense code n; enables stay off so nothing reaches the CPU.
    // Line 2 starts low so that its rising edge can be made; the others start high.
    for (int m = 0; m < 4; m++)
    begin
      pins[m] = (m != 2);
      sense[2*m +: 2] = m[1:0];
      cyc(3);
      chk(flags[m], 0);
      pins[m] = ~pins[m];
      cyc(2);
      chk(flags[m], 1);
      chk(creq, 0);
      clr[m] = 1;
      cyc(1);
      clr = '0;
      cyc(2);
      chk(flags[m], m == 0);
    end
    // The sense codes change with the pins, so restoring the pins raises no new request.
    pins = '1;
    sense = 12'h001;
    clr = '1;
    cyc(1);
    clr = '0;
    cyc(2);
    chk(flags, 0);
    $display("sense test done");
    en[0] = 1;
    auto_ack = 1;
    pins[0] = 0;
    cyc(2);
    chk(vn, 8'h10);
    chk(va, 16'h0040);
    chk(wake, 1);
    cyc(6);
    chk(flags[0], 0);
    chk(creq, 0);
    auto_ack = 0;
    en = '0;
    $display("handling test done");
    pf = {1'b1, 47'h0, 1'b1};
    pe = pf;
    cyc(2);
    chk(vn, 8'h18);
    use_lv = 1;
    lvl[18*3 +: 3] = 3'h5;
    cyc(2);
    chk(vn, 8'h6e);
    chk(rl, 3'h5);
    lvl[4*3 +: 3] = 3'h5;
    cyc(2);
    chk(vn, 8'h18);
    pd[0] = 1;
    cyc(2);
    chk(dreq, 1);
    chk(dv, 8'h18);
    chk(vn, 8'h6e);
    $display("priority test done");
    nmi = 0;
    cyc(2);
    chk({np, wake}, 2'h3);
    chk(vn, 8'h07);
    chk(va, 16'h001c);
    chk(rl, 3'h7);
    // The CPU model takes the non-maskable request, then the rising polarity is tried.
    auto_ack = 1;
    cyc(5);
    chk(np, 0);
    auto_ack = 0;
    nes = 1;
    nmi = 1;
    cyc(2);
    chk(np, 1);
    chk(vn, 8'h07);
    $display("nonmaskable test done");
    final_report();
  end
endmodule : interrupt_source_priority_logic_bench
`default_nettype wire

// ==== dv/isp_cpu_model.sv ====
// CPU core model that answers requests with exception handling.
`timescale 1ns/1ps
`default_nettype none
module isp_cpu_model
  import isp_pkg::*;
(
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      auto_i,
  input  wire logic                      req_i,
  input  wire logic [isp_pkg::VEC_W-1:0] vec_i,
  output logic                           ack_o,
  output logic [isp_pkg::VEC_W-1:0]      ack_vec_o
);
  import isp_pkg::*;

  logic [1:0] wait_cnt;
  // ----------------------------------------------------------------
  // Acceptance
  // ----------------------------------------------------------------
  // handling after delay
  always_ff @(posedge clk_i)
  begin
    ack_o <= 1'b0;
    if (rst_i || !auto_i || !req_i || ack_o)
    begin
      wait_cnt <= 2'h0;
    end
    else if (wait_cnt == 2'h2)
    begin
      ack_o     <= 1'b1;
      ack_vec_o <= vec_i;
      wait_cnt  <= 2'h0;
    end
    else
    begin
      wait_cnt <= wait_cnt + 2'h1;
    end
  end
endmodule : isp_cpu_model
`default_nettype wire

// ==== dv/isp_top_props.sv ====
// Port-level checks for the interrupt source and priority logic.
`timescale 1ns/1ps
`default_nettype none
module isp_top_props
  import isp_pkg::*;
(
  input wire logic                        clk_i,
  input wire logic                        rst_i,
  input wire logic [isp_pkg::N_EXT-1:0]   external_request_lines_i,
  input wire logic [2*isp_pkg::N_EXT-1:0] sense_control_setting_i,
  input wire logic                        use_levels_i,
  input wire logic [isp_pkg::N_PER-1:0]   periph_flag_i,
  input wire logic [isp_pkg::N_PER-1:0]   periph_enable_i,
  input wire logic [isp_pkg::N_PER-1:0]   periph_to_dtc_i,
  input wire logic [isp_pkg::N_EXT-1:0]   request_status_flags_o,
  input wire logic                        wake_o,
  input wire logic                        nmi_pending_o,
  input wire logic                        cpu_request_o,
  input wire logic [isp_pkg::VEC_W-1:0]   vector_number_o,
  input wire logic [isp_pkg::ADDR_W-1:0]  vector_address_o,
  input wire logic [isp_pkg::LVL_W-1:0]   request_level_o,
  input wire logic                        dtc_request_o
);
  import isp_pkg::*;

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_addr; vector_address_o == {6'h0, vector_number_o, 2'h0}; endproperty
  a_addr: assert property (p_addr) else $error("vector address not four times vector");
  property p_rsv; cpu_request_o |-> !(vector_number_o inside {8'h16, 8'h17, 8'h6f}); endproperty
  a_rsv: assert property (p_rsv) else $error("reserved vector produced");
  property p_nmi; nmi_pending_o |-> cpu_request_o && vector_number_o == 8'h07; endproperty
  a_nmi: assert property (p_nmi) else $error("nonmaskable request not presented");
  property p_wake; nmi_pending_o |-> wake_o; endproperty
  a_wake: assert property (p_wake) else $error("no wake on nonmaskable request");
  property p_flag;
    sense_control_setting_i[1:0] == 2'h1 && $fell(external_request_lines_i[0]) |-> ##2 request_status_flags_o[0];
  endproperty
  a_flag: assert property (p_flag) else $error("falling edge did not set flag");
  property p_per; !$past(rst_i) && |(periph_flag_i & periph_enable_i & ~periph_to_dtc_i) |=> cpu_request_o; endproperty
  a_per: assert property (p_per) else $error("peripheral request not raised");
  property p_dtc; !$past(rst_i) && |(periph_flag_i & periph_enable_i & periph_to_dtc_i) |=> dtc_request_o; endproperty
  a_dtc: assert property (p_dtc) else $error("transfer controller not started");
  property p_lvl; !use_levels_i ##1 !nmi_pending_o |-> request_level_o == 3'h0; endproperty
  a_lvl: assert property (p_lvl) else $error("level shown in default order");
endmodule : isp_top_props
bind isp_top isp_top_props u_props (.*);
`default_nettype wire

// ==== hw/isp_arb_if.sv ====
// Carrier between the top level and the priority resolver.
`timescale 1ns/1ps
`default_nettype none
interface isp_arb_if;
  import isp_pkg::*;

  logic [N_SRC-1:0]       req;
  logic [N_SRC-1:0]       to_dtc;
  logic [LVL_W-1:0]       lvl [N_GRP];
  logic                   use_levels;
  logic                   cpu_valid;
  logic [IDX_W-1:0]       cpu_idx;
  logic [LVL_W-1:0]       cpu_lvl;
  logic                   dtc_valid;
  logic [IDX_W-1:0]       dtc_idx;

  modport src (output req, output to_dtc, output lvl, output use_levels,
               input cpu_valid, input cpu_idx, input cpu_lvl, input dtc_valid, input dtc_idx);
  modport arb (input req, input to_dtc, input lvl, input use_levels,
               output cpu_valid, output cpu_idx, output cpu_lvl, output dtc_valid, output dtc_idx);
endinterface : isp_arb_if
`default_nettype wire

// ==== hw/isp_pkg.sv ====
// Constants and source tables for the interrupt source and priority logic.
package isp_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int N_EXT    = 6;
  localparam int N_PER    = 49;
  localparam int N_SRC    = N_EXT + N_PER;
  localparam int N_GRP    = 19;
  localparam int LVL_W    = 3;
  localparam int IDX_W    = 6;
  localparam int VEC_W    = 8;
  localparam int ADDR_W   = 16;

  // ----------------------------------------------------------------
  // Sense control codes
  // ----------------------------------------------------------------
  localparam logic [1:0] SENSE_LOW  = 2'h0;
  localparam logic [1:0] SENSE_FALL = 2'h1;
  localparam logic [1:0] SENSE_RISE = 2'h2;
  localparam logic [1:0] SENSE_BOTH = 2'h3;

  // ----------------------------------------------------------------
  // Fixed vectors and reset values
  // ----------------------------------------------------------------
  localparam logic [VEC_W-1:0] NMI_VECTOR  = 8'h07;
  localparam logic [LVL_W-1:0] NMI_LEVEL   = 3'h7;
  localparam logic             PIN_IDLE    = 1'h1;
  localparam int               ADDR_SHIFT  = 2;

  // Vector of each maskable source, in default order (lowest vector first).
  // Vectors 22, 23 and 111 are reserved and absent from this table.
  localparam logic [VEC_W-1:0] SRC_VEC [N_SRC] = '{
    8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15,
    8'h18, 8'h19, 8'h1b, 8'h1c,
    8'h20, 8'h21, 8'h22, 8'h23, 8'h24,
    8'h28, 8'h29, 8'h2a, 8'h2b,
    8'h2c, 8'h2d, 8'h2e, 8'h2f,
    8'h30, 8'h31, 8'h32, 8'h33, 8'h34,
    8'h38, 8'h39, 8'h3a, 8'h3b,
    8'h3c, 8'h3d, 8'h3e, 8'h3f,
    8'h50, 8'h51, 8'h52, 8'h53,
    8'h54, 8'h55, 8'h56, 8'h57,
    8'h58, 8'h59, 8'h5a, 8'h5b,
    8'h68, 8'h69, 8'h6a, 8'h6b,
    8'h6c, 8'h6d, 8'h6e
  };

  // Priority level field that governs each source.
  localparam int SRC_GRP [N_SRC] = '{
    0, 1, 2, 2, 3, 3,
    4, 5, 6, 7,
    8, 8, 8, 8, 8,
    9, 9, 9, 9,
    10, 10, 10, 10,
    11, 11, 11, 11, 11,
    12, 12, 12, 12,
    13, 13, 13, 13,
    14, 14, 14, 14,
    15, 15, 15, 15,
    16, 16, 16, 16,
    17, 17, 17, 17,
    18, 18, 18
  };

endpackage : isp_pkg

// ==== hw/isp_resolver.sv ====
// Priority resolver for CPU and data transfer controller requests.
`timescale 1ns/1ps
`default_nettype none
module isp_resolver
  import isp_pkg::*;
(
  isp_arb_if.arb arb
);
  import isp_pkg::*;

  logic             found;
  logic [LVL_W-1:0] best_lvl;
  logic [IDX_W-1:0] best_idx;
  logic [LVL_W-1:0] cand_lvl;
  logic             dfound;
  logic [IDX_W-1:0] didx;

  // The table runs in vector order, so a strict compare keeps the lower vector on ties.
  // lower vector wins
  always_comb
  begin
    found    = 1'b0;
    best_lvl = '0;
    best_idx = '0;
    cand_lvl = '0;
    for (int i = 0; i < N_SRC; i++)
    begin
      cand_lvl = arb.use_levels ? arb.lvl[SRC_GRP[i]] : '0;
      if (arb.req[i] && !arb.to_dtc[i] && (!found || cand_lvl > best_lvl))
      begin
        found    = 1'b1;
        best_lvl = cand_lvl;
        best_idx = IDX_W'(i);
      end
    end
  end

  always_comb
  begin
    dfound = 1'b0;
    didx   = '0;
    for (int i = 0; i < N_SRC; i++)
    begin
      if (arb.req[i] && arb.to_dtc[i] && !dfound)
      begin
        dfound = 1'b1;
        didx   = IDX_W'(i);
      end
    end
  end

  assign arb.cpu_valid = found;
  assign arb.cpu_idx   = best_idx;
  assign arb.cpu_lvl   = best_lvl;
  assign arb.dtc_valid = dfound;
  assign arb.dtc_idx   = didx;

endmodule : isp_resolver
`default_nettype wire

// ==== hw/isp_sense_unit.sv ====
// Sense detector and status flag for one external request line.
`timescale 1ns/1ps
`default_nettype none
module isp_sense_unit
  import isp_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       pin_i,
  input  wire logic [1:0] sense_i,
  input  wire logic       sw_clear_i,
  input  wire logic       handled_i,
  output logic            flag_o
);
  import isp_pkg::*;

  logic pin_prev;
  logic detect;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pin_prev <= PIN_IDLE;
    else
      pin_prev <= pin_i;
  end

  always_comb
  begin
    unique case (sense_i)
      SENSE_LOW:  detect = ~pin_i;
      SENSE_FALL: detect = pin_prev & ~pin_i;
      SENSE_RISE: detect = ~pin_prev & pin_i;
      SENSE_BOTH: detect = pin_prev ^ pin_i;
    endcase
  end

  // A new detection in the clearing cycle wins, so no request is lost.
  // software flag clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      flag_o <= 1'b0;
    else if (detect)
      flag_o <= 1'b1;
    else if (sw_clear_i)
      flag_o <= 1'b0;
    else if (handled_i && (sense_i != SENSE_LOW || pin_i))
      flag_o <= 1'b0;
  end

endmodule : isp_sense_unit
`default_nettype wire

// ==== hw/isp_top.sv ====
// Interrupt source and priority logic: detection, flags, arbitration and vectors.
//
// Functional notes
// - Seven external inputs, all able to wake
// - Non-maskable request highest, always presented
// - Edge select picks rising or falling
// - Six lines sense level or edges
// - Codes: 00 low, 01 fall, 10 rise, 11 both
// - Per-line enable gates the request
// - Each line takes a programmed level
// - Status flags shown, software clears them
// - Flags set on sense, auto-clear on handling
// - Detection regardless of pin direction
// - Peripheral request needs flag and enable
// - Peripheral requests may start transfer controller
// - Controller start ignores mode and mask
// - Lower vector number has higher priority
// - Programmed levels, ties by default order
// - Vector 7 and vectors 16 to 21
// - Address is low 16 bits, 24 to 110
// - Vectors 22, 23, 111 never produced
// - Paired line fields, one per channel
`timescale 1ns/1ps
`default_nettype none
module isp_top
  import isp_pkg::*;
(
  input  wire logic                             clk_i,
  input  wire logic                             rst_i,
  input  wire logic                             nmi_pin_i,
  input  wire logic                             nonmaskable_edge_select_i,
  input  wire logic [isp_pkg::N_EXT-1:0]        external_request_lines_i,
  input  wire logic [2*isp_pkg::N_EXT-1:0]      sense_control_setting_i,
  input  wire logic [isp_pkg::N_EXT-1:0]        request_enable_bits_i,
  input  wire logic [isp_pkg::N_EXT-1:0]        status_clear_i,
  input  wire logic [isp_pkg::N_GRP*isp_pkg::LVL_W-1:0] priority_level_fields_i,
  input  wire logic                             use_levels_i,
  input  wire logic [isp_pkg::N_PER-1:0]        periph_flag_i,
  input  wire logic [isp_pkg::N_PER-1:0]        periph_enable_i,
  input  wire logic [isp_pkg::N_PER-1:0]        periph_to_dtc_i,
  input  wire logic                             handled_i,
  input  wire logic [isp_pkg::VEC_W-1:0]        handled_vector_i,
  output logic [isp_pkg::N_EXT-1:0]             request_status_flags_o,
  output logic                                  wake_o,
  output logic                                  nmi_pending_o,
  output logic                                  cpu_request_o,
  output logic [isp_pkg::VEC_W-1:0]             vector_number_o,
  output logic [isp_pkg::ADDR_W-1:0]            vector_address_o,
  output logic [isp_pkg::LVL_W-1:0]             request_level_o,
  output logic                                  dtc_request_o,
  output logic [isp_pkg::VEC_W-1:0]             dtc_vector_o
);
  import isp_pkg::*;

  // ----------------------------------------------------------------
  // Non-maskable input
  // ----------------------------------------------------------------
  logic nmi_prev;
  logic nmi_edge;
  logic nmi_flag;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      nmi_prev <= PIN_IDLE;
    else
      nmi_prev <= nmi_pin_i;
  end

  assign nmi_edge = nonmaskable_edge_select_i ? (~nmi_prev & nmi_pin_i) : (nmi_prev & ~nmi_pin_i);

  // The flag stays until its own handling, so a late edge is never dropped.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      nmi_flag <= 1'b0;
    else if (nmi_edge)
      nmi_flag <= 1'b1;
    else if (handled_i && handled_vector_i == NMI_VECTOR)
      nmi_flag <= 1'b0;
  end

  // ----------------------------------------------------------------
  // External request lines
  // ----------------------------------------------------------------
  logic [N_EXT-1:0] ext_flag;

  // Pins are read directly, so the port direction setting has no effect.
  // direction-independent detection
  for (genvar n = 0; n < N_EXT; n++)
  begin : g_line
    isp_sense_unit u_sense (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .pin_i      (external_request_lines_i[n]),
      .sense_i    (sense_control_setting_i[2*n +: 2]),
      .sw_clear_i (status_clear_i[n]),
      .handled_i  (handled_i && handled_vector_i == SRC_VEC[n]),
      .flag_o     (ext_flag[n])
    );
  end

  // ----------------------------------------------------------------
  // Arbitration
  // ----------------------------------------------------------------
  isp_arb_if arb_if ();

  assign arb_if.req        = {periph_flag_i & periph_enable_i, ext_flag & request_enable_bits_i};
  assign arb_if.to_dtc     = {periph_to_dtc_i, {N_EXT{1'b0}}};
  assign arb_if.use_levels = use_levels_i;

  // Lines 2/3 and 4/5 share one field each; the shared fields follow from the group table.
  // line level assignment
  for (genvar g = 0; g < N_GRP; g++)
  begin : g_lvl
    assign arb_if.lvl[g] = priority_level_fields_i[g*LVL_W +: LVL_W];
  end

  isp_resolver u_resolver (
    .arb (arb_if.arb)
  );

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  logic [VEC_W-1:0] next_vector;
  logic [LVL_W-1:0] next_level;

  // The non-maskable source is offered ahead of every other and is not gated here.
  // non-maskable first
  always_comb
  begin
    if (nmi_flag)
    begin
      next_vector = NMI_VECTOR;
      next_level  = NMI_LEVEL;
    end
    else
    begin
      next_vector = SRC_VEC[arb_if.cpu_idx];
      next_level  = arb_if.cpu_lvl;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cpu_request_o   <= 1'b0;
      nmi_pending_o   <= 1'b0;
      vector_number_o <= '0;
      request_level_o <= '0;
    end
    else
    begin
      cpu_request_o   <= nmi_flag | arb_if.cpu_valid;
      nmi_pending_o   <= nmi_flag;
      vector_number_o <= next_vector;
      request_level_o <= next_level;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      vector_address_o <= '0;
    else
      vector_address_o <= ADDR_W'({next_vector, 2'b00});
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dtc_request_o <= 1'b0;
      dtc_vector_o  <= '0;
    end
    else
    begin
      dtc_request_o <= arb_if.dtc_valid;
      dtc_vector_o  <= SRC_VEC[arb_if.dtc_idx];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      request_status_flags_o <= '0;
    else
      request_status_flags_o <= ext_flag;
  end

  // Wake uses the flags gated only by the line enables, so standby exit does not depend on the CPU mask.
  // wake on NMI or any enabled line
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wake_o <= 1'b0;
    else
      wake_o <= nmi_flag | (|(ext_flag & request_enable_bits_i));
  end

endmodule : isp_top
`default_nettype wire
